// File: src/scc_pkg.sv
package scc_pkg;

    localparam int SCC_REG_AW = 12;
    localparam logic [11:0] SCC_OFS_VGA_WP = 12'h038;
    localparam logic [11:0] SCC_OFS_VGA_RP = 12'h03c;
    localparam logic [11:0] SCC_OFS_CNTL = 12'h140;
    localparam logic [11:0] SCC_OFS_ADDR = 12'h148;

    localparam logic [31:0] SCC_CNTL_RST = 32'h0800_0000;
    localparam logic [31:0] SCC_ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] SCC_VGA_RST = 32'h0000_0000;
    localparam logic [31:0] SCC_CNTL_WMASK = 32'hff8f_f7fb;
    localparam logic [31:0] SCC_ADDR_WMASK = 32'h0033_017f;
    localparam logic [31:0] SCC_VGA_WMASK = 32'h03ff_03ff;

    localparam int SCC_TYPE_LSB = 0;
    localparam int SCC_BWCOL_BIT = 3;
    localparam int SCC_CAPD_LSB = 4;
    localparam int SCC_RCVD_LSB = 6;
    localparam int SCC_LAT_LSB = 8;
    localparam int SCC_WRLAT_LSB = 12;
    localparam int SCC_WDRV_LSB = 14;
    localparam int SCC_OPER_LSB = 16;
    localparam int SCC_CBUSY_BIT = 20;
    localparam int SCC_SBUSY_BIT = 21;
    localparam int SCC_ABUSY_BIT = 22;
    localparam int SCC_LOCK_BIT = 23;
    localparam int SCC_CAPX_BIT = 24;
    localparam int SCC_RCVX_BIT = 25;
    localparam int SCC_DQMD_BIT = 26;
    localparam int SCC_REFD_BIT = 27;
    localparam int SCC_RATE_LSB = 28;
    localparam int SCC_MAP_LSB = 0;
    localparam int SCC_AP_LSB = 4;
    localparam int SCC_BUS_BIT = 8;
    localparam int SCC_CHK_LSB = 16;
    localparam int SCC_BLK_LSB = 20;

    localparam int SCC_ROW_W = 14;
    localparam int SCC_COL_W = 8;
    localparam int SCC_AP_W = 13;
    localparam int SCC_AP_BASE = 8;
    localparam logic [2:0] SCC_AP_MAX = 3'h4;
    localparam int SCC_CHK_BASE = 10;
    localparam int SCC_CS2_ROW_BIT = 12;
    localparam int SCC_CS3_ROW_BIT = 13;
    localparam int SCC_SHIFT_64 = 3;
    localparam int SCC_SHIFT_128 = 4;
    localparam logic [1:0] SCC_BLK_NOMASK = 2'h2;
    localparam logic [1:0] SCC_BLK_MASK = 2'h3;
    localparam logic [4:0] SCC_BW_COLS_8 = 5'h08;
    localparam logic [4:0] SCC_BW_COLS_16 = 5'h10;
    localparam logic [3:0] SCC_OPER_NO_HIDE = 4'h1;
    localparam logic [1:0] SCC_DELAY_ALWAYS = 2'h3;
    localparam logic [2:0] SCC_LAT_MAX = 3'h3;
    localparam logic [2:0] SCC_CL_MIN = 3'h2;
    localparam logic [2:0] SCC_CL_MAX = 3'h3;
    localparam logic [4:0] SCC_WIN_HALVES = 5'h02;
    localparam logic [4:0] SCC_WIN_STRETCH = 5'h04;
    localparam logic [1:0] SCC_WRLAT_MAX = 2'h2;
    localparam int SCC_REF_W = 11;

    typedef enum logic [1:0] {
        SCC_SDR_1TO1 = 2'b00,
        SCC_SDR_2TO1 = 2'b01,
        SCC_DDR = 2'b10
    } scc_if_type_e;

    typedef struct packed {
        logic [3:0] rows;
        logic col8;
        logic bank4;
        logic cs2;
        logic cs3;
    } scc_map_s;

    function automatic scc_map_s scc_map_decode(input logic [3:0] code);
        unique case (code)
            4'h0: return '{4'h9, 1'b1, 1'b0, 1'b0, 1'b0};
            4'h1: return '{4'ha, 1'b1, 1'b0, 1'b0, 1'b0};
            4'h2: return '{4'hb, 1'b1, 1'b0, 1'b1, 1'b0};
            4'h4: return '{4'hd, 1'b1, 1'b0, 1'b1, 1'b1};
            4'h8: return '{4'h9, 1'b1, 1'b1, 1'b0, 1'b0};
            4'h9: return '{4'ha, 1'b0, 1'b1, 1'b0, 1'b0};
            4'ha: return '{4'ha, 1'b0, 1'b1, 1'b1, 1'b0};
            4'hc: return '{4'hb, 1'b0, 1'b1, 1'b1, 1'b0};
            4'hd: return '{4'hc, 1'b1, 1'b1, 1'b1, 1'b1};
            default: return '{4'h9, 1'b1, 1'b0, 1'b0, 1'b0};
        endcase
    endfunction

    function automatic logic [SCC_REF_W-1:0] scc_refresh_interval(input logic [3:0] code);
        unique case (code)
            4'h0: return 11'd156;
            4'h1: return 11'd781;
            4'h2: return 11'd1031;
            4'h3: return 11'd1172;
            4'h4: return 11'd1297;
            4'h5: return 11'd1406;
            4'h6: return 11'd1484;
            4'h7: return 11'd1563;
            4'h8: return 11'd1641;
            4'h9: return 11'd1719;
            4'ha: return 11'd1797;
            4'hb: return 11'd1875;
            4'hc: return 11'd1953;
            default: return 11'd156;
        endcase
    endfunction

endpackage

// File: src/scc_core.sv
`timescale 1ns/100ps
module scc_core
    import scc_pkg::*;
#(
    parameter int LIN_W = 32,
    parameter int HIST_D = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [SCC_REG_AW-1:0] reg_addr,
    input wire logic [3:0] reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rd_valid,
    input wire logic [2:0] cas_latency,
    input wire logic sequencer_busy_in,
    input wire logic arbiter_busy_in,
    input wire logic client_req_valid,
    input wire logic [LIN_W-1:0] client_byte_addr,
    output logic client_req_ready,
    output logic client_req_taken,
    output logic [SCC_ROW_W-1:0] row_addr,
    output logic [SCC_COL_W-1:0] col_addr,
    output logic [1:0] bank_addr,
    output logic third_chip_select,
    output logic fourth_chip_select,
    output logic [SCC_AP_W-1:0] autoprecharge_mask,
    output logic [1:0] mem_if_type,
    output logic wide_data_bus,
    output logic block_write_enable,
    output logic block_write_byte_mask,
    output logic [4:0] block_write_columns,
    output logic [3:0] sequencer_operating_mode,
    output logic page_hiding_disable,
    input wire logic read_cmd,
    output logic read_capture_enable_rise,
    output logic read_capture_enable_fall,
    output logic data_receive_enable_rise,
    output logic data_receive_enable_fall,
    output logic read_data_latch,
    output logic dqm_on_read,
    output logic [1:0] write_data_delay_halves,
    output logic [1:0] write_drive_timing,
    output logic refresh_req
);

    logic [31:0] cntl_reg;
    logic [31:0] addr_reg;
    logic [31:0] vga_wp_reg;
    logic [31:0] vga_rp_reg;
    logic [31:0] rdata_reg;
    logic rd_valid_reg;
    logic [HIST_D-1:0] hist_reg;
    logic [SCC_REF_W-1:0] ref_cnt_reg;
    logic ref_req_reg;
    logic taken_reg;
    logic [SCC_ROW_W-1:0] row_reg;
    logic [SCC_COL_W-1:0] col_reg;
    logic [1:0] bank_reg;
    logic cs2_reg;
    logic cs3_reg;

    function automatic logic [31:0] merge_write(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be, input logic [31:0] wm);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{be[b]}};
        end
        m = m & wm;
        return (old & ~m) | (wd & m);
    endfunction

    // Slot index counts half clocks from the read command; entry i is i+1 clocks old
    function automatic logic win_hit(input logic [HIST_D-1:0] h, input logic [4:0] d,
                                     input logic [4:0] w, input logic half);
        logic hit;
        logic [4:0] idx;
        hit = 1'b0;
        idx = '0;
        for (int i = 0; i < HIST_D; i++) begin
            idx = 5'(2 * i + 2) + {4'h0, half};
            if (h[i] && idx >= d && idx < d + w) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Register decode
    wire sel_cntl = reg_addr == SCC_OFS_CNTL;
    wire sel_addr = reg_addr == SCC_OFS_ADDR;
    wire sel_wp = reg_addr == SCC_OFS_VGA_WP;
    wire sel_rp = reg_addr == SCC_OFS_VGA_RP;
    wire ctlr_busy = sequencer_busy_in | arbiter_busy_in;
    // Busy bits are never stored, so a write there has nothing to land on
    wire [31:0] cntl_view = cntl_reg
                          | (32'(ctlr_busy) << SCC_CBUSY_BIT)
                          | (32'(sequencer_busy_in) << SCC_SBUSY_BIT)
                          | (32'(arbiter_busy_in) << SCC_ABUSY_BIT);
    wire [31:0] rd_mux = sel_cntl ? cntl_view :
                         sel_addr ? addr_reg :
                         sel_wp ? vga_wp_reg :
                         sel_rp ? vga_rp_reg : 32'h0000_0000;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cntl_reg <= SCC_CNTL_RST;
            addr_reg <= SCC_ADDR_RST;
            vga_wp_reg <= SCC_VGA_RST;
            vga_rp_reg <= SCC_VGA_RST;
        end else if (ce && reg_wr) begin
            if (sel_cntl) begin
                cntl_reg <= merge_write(cntl_reg, reg_wdata, reg_be, SCC_CNTL_WMASK);
            end
            if (sel_addr) begin
                addr_reg <= merge_write(addr_reg, reg_wdata, reg_be, SCC_ADDR_WMASK);
            end
            if (sel_wp) begin
                vga_wp_reg <= merge_write(vga_wp_reg, reg_wdata, reg_be, SCC_VGA_WMASK);
            end
            if (sel_rp) begin
                vga_rp_reg <= merge_write(vga_rp_reg, reg_wdata, reg_be, SCC_VGA_WMASK);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_reg <= '0;
            rd_valid_reg <= 1'b0;
        end else if (ce) begin
            rd_valid_reg <= reg_rd;
            if (reg_rd) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rd_valid = rd_valid_reg;

    // Field views
    wire [1:0] if_type = cntl_reg[SCC_TYPE_LSB +: 2];
    wire [1:0] cap_code = cntl_reg[SCC_CAPD_LSB +: 2];
    wire [1:0] rcv_code = cntl_reg[SCC_RCVD_LSB +: 2];
    wire [2:0] lat_code = cntl_reg[SCC_LAT_LSB +: 3];
    wire [1:0] wrlat_code = cntl_reg[SCC_WRLAT_LSB +: 2];
    wire req_lock = cntl_reg[SCC_LOCK_BIT];
    wire refresh_disable = cntl_reg[SCC_REFD_BIT];
    wire [3:0] rate_code = cntl_reg[SCC_RATE_LSB +: 4];
    wire [3:0] map_code = addr_reg[SCC_MAP_LSB +: 4];
    wire [2:0] ap_code = addr_reg[SCC_AP_LSB +: 3];
    wire [1:0] chk_code = addr_reg[SCC_CHK_LSB +: 2];
    wire [1:0] blk_code = addr_reg[SCC_BLK_LSB +: 2];
    wire two_to_one = (if_type == SCC_SDR_2TO1) || (if_type == SCC_DDR);

    assign mem_if_type = if_type;
    assign wide_data_bus = addr_reg[SCC_BUS_BIT];
    assign block_write_enable = blk_code == SCC_BLK_NOMASK || blk_code == SCC_BLK_MASK;
    assign block_write_byte_mask = blk_code == SCC_BLK_MASK;
    assign block_write_columns = cntl_reg[SCC_BWCOL_BIT] ? SCC_BW_COLS_16 : SCC_BW_COLS_8;
    assign sequencer_operating_mode = cntl_reg[SCC_OPER_LSB +: 4];
    assign page_hiding_disable = sequencer_operating_mode == SCC_OPER_NO_HIDE;
    // Out-of-range codes clamp to the last legal value rather than alias
    wire [2:0] ap_sel = (ap_code > SCC_AP_MAX) ? SCC_AP_MAX : ap_code;
    assign autoprecharge_mask = SCC_AP_W'(1) << (SCC_AP_BASE + int'(ap_sel));
    assign write_data_delay_halves = (wrlat_code > SCC_WRLAT_MAX) ? SCC_WRLAT_MAX : wrlat_code;
    assign write_drive_timing = cntl_reg[SCC_WDRV_LSB +: 2];
    assign dqm_on_read = read_cmd & ~cntl_reg[SCC_DQMD_BIT];

    // Client address path
    assign client_req_ready = ~req_lock;
    wire take = ce & client_req_valid & client_req_ready;
    scc_map_s map_cur;
    assign map_cur = scc_map_decode(map_code);
    wire [LIN_W-1:0] flipped = client_byte_addr ^ (LIN_W'(1) << (SCC_CHK_BASE + int'(chk_code)));
    wire [LIN_W-1:0] word_addr = flipped >> (wide_data_bus ? SCC_SHIFT_128 : SCC_SHIFT_64);
    wire [LIN_W-1:0] col_part = map_cur.col8 ? word_addr : (word_addr & LIN_W'(8'h7f));
    wire [LIN_W-1:0] above_col = word_addr >> (map_cur.col8 ? SCC_COL_W : SCC_COL_W - 1);
    wire [1:0] bank_part = map_cur.bank4 ? above_col[1:0] : {1'b0, above_col[0]};
    wire [LIN_W-1:0] above_bank = above_col >> (map_cur.bank4 ? 2 : 1);
    wire [SCC_ROW_W-1:0] row_mask = SCC_ROW_W'((SCC_ROW_W+1)'(1) << map_cur.rows) - SCC_ROW_W'(1);
    wire [SCC_ROW_W-1:0] row_part = above_bank[SCC_ROW_W-1:0] & row_mask;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            taken_reg <= 1'b0;
            row_reg <= '0;
            col_reg <= '0;
            bank_reg <= '0;
            cs2_reg <= 1'b0;
            cs3_reg <= 1'b0;
        end else if (ce) begin
            taken_reg <= take;
            if (take) begin
                row_reg <= row_part;
                col_reg <= col_part[SCC_COL_W-1:0];
                bank_reg <= bank_part;
                // Taken from fixed above_bank bits 12 and 13, which map code 4 also drives onto row bit 12
                cs2_reg <= map_cur.cs2 & above_bank[SCC_CS2_ROW_BIT];
                cs3_reg <= map_cur.cs3 & above_bank[SCC_CS3_ROW_BIT];
            end
        end
    end

    assign client_req_taken = taken_reg;
    assign row_addr = row_reg;
    assign col_addr = col_reg;
    assign bank_addr = bank_reg;
    assign third_chip_select = cs2_reg;
    assign fourth_chip_select = cs3_reg;

    // Read timing; half-clock placement is shown as a rise and a fall phase of each clock
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hist_reg <= '0;
        end else if (ce) begin
            hist_reg <= {hist_reg[HIST_D-2:0], read_cmd};
        end
    end

    wire [2:0] cl_eff = (cas_latency == SCC_CL_MIN) ? SCC_CL_MIN : SCC_CL_MAX;
    wire [4:0] cl_halves = {1'b0, cl_eff, 1'b0} - SCC_WIN_HALVES;
    wire [4:0] cap_d = cl_halves + {3'h0, cap_code};
    wire [4:0] rcv_d = cl_halves + {3'h0, rcv_code};
    wire [4:0] cap_w = cntl_reg[SCC_CAPX_BIT] ? SCC_WIN_STRETCH : SCC_WIN_HALVES;
    wire [4:0] rcv_w = cntl_reg[SCC_RCVX_BIT] ? SCC_WIN_STRETCH : SCC_WIN_HALVES;
    wire cap_always = cap_code == SCC_DELAY_ALWAYS;
    wire rcv_always = rcv_code == SCC_DELAY_ALWAYS;

    assign read_capture_enable_rise = two_to_one & (cap_always | win_hit(hist_reg, cap_d, cap_w, 1'b0));
    assign read_capture_enable_fall = two_to_one & (cap_always | win_hit(hist_reg, cap_d, cap_w, 1'b1));
    assign data_receive_enable_rise = two_to_one & (rcv_always | win_hit(hist_reg, rcv_d, rcv_w, 1'b0));
    assign data_receive_enable_fall = two_to_one & (rcv_always | win_hit(hist_reg, rcv_d, rcv_w, 1'b1));
    wire [2:0] lat_sel = (lat_code > SCC_LAT_MAX) ? SCC_LAT_MAX : lat_code;
    assign read_data_latch = hist_reg[lat_sel];

    // Refresh timer; held at reload while disabled so enabling gives a full first interval
    wire [SCC_REF_W-1:0] ref_reload = scc_refresh_interval(rate_code) - SCC_REF_W'(1);
    wire ref_expire = ~refresh_disable && ref_cnt_reg == '0;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ref_cnt_reg <= '0;
            ref_req_reg <= 1'b0;
        end else if (ce) begin
            ref_req_reg <= ref_expire;
            if (refresh_disable || ref_expire) begin
                ref_cnt_reg <= ref_reload;
            end else begin
                ref_cnt_reg <= ref_cnt_reg - SCC_REF_W'(1);
            end
        end
    end

    assign refresh_req = ref_req_reg & ~refresh_disable;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || !ce);

    sequence s_read_cl3_at_cl;
        read_cmd && two_to_one && cap_code == 2'h2 && cl_eff == SCC_CL_MAX;
    endsequence

    a_lock_blocks_clients: assert property (req_lock |-> !client_req_ready && !take)
        else $error("client request accepted while locked");
    a_refresh_off_quiet: assert property (refresh_disable |-> !refresh_req)
        else $error("refresh requested while disabled");
    a_refresh_reload_now: assert property (ref_expire |=> ref_req_reg && ref_cnt_reg == $past(ref_reload))
        else $error("refresh counter did not reload on expiry");
    a_reset_refresh_off: assert property ($past(rst) |-> cntl_reg[SCC_REFD_BIT])
        else $error("refresh disable not set after reset");
    a_latch_one_clock: assert property (read_cmd && lat_sel == 3'h0 |=> read_data_latch)
        else $error("read data latch missed one clock delay");
    a_latch_four_clock: assert property (read_cmd && lat_sel == 3'h3 && $stable(lat_sel) |-> ##4 read_data_latch)
        else $error("read data latch missed four clock delay");
    a_capture_at_cl: assert property (s_read_cl3_at_cl ##1 $stable(cntl_reg)[*2] |=> read_capture_enable_rise)
        else $error("capture enable not at CAS latency");
    a_single_rate_off: assert property (if_type == SCC_SDR_1TO1 |-> !read_capture_enable_rise && !data_receive_enable_fall)
        else $error("read enable active in 1:1 mode");
    a_stretch_extra: assert property (read_cmd && two_to_one && cap_code == 2'h0 && cl_eff == SCC_CL_MIN
                                      && cntl_reg[SCC_CAPX_BIT] ##1 $stable(cntl_reg) |=> read_capture_enable_rise)
        else $error("stretched capture enable missing second clock");
    a_read_mask_off: assert property (cntl_reg[SCC_DQMD_BIT] |-> !dqm_on_read)
        else $error("data mask on read while disabled");
    a_busy_readback: assert property (reg_rd && sel_cntl |=> reg_rdata[SCC_SBUSY_BIT] == $past(sequencer_busy_in)
                                      && reg_rdata[SCC_CBUSY_BIT] == $past(ctlr_busy))
        else $error("busy bits read back wrong");
    a_busy_not_stored: assert property (cntl_reg[SCC_ABUSY_BIT:SCC_CBUSY_BIT] == 3'h0)
        else $error("busy position holds written data");
    a_no_cs3_map: assert property (take && !map_cur.cs3 |=> !fourth_chip_select)
        else $error("fourth select driven for mapping without it");
    a_block_write_off: assert property (blk_code < SCC_BLK_NOMASK |-> !block_write_enable)
        else $error("block write enabled by disabled code");

endmodule

// File: verification/scc_seq_model.sv
`timescale 1ns/100ps
module scc_seq_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic refresh_req,
    input wire logic rd_go,
    output logic read_cmd,
    output logic seq_busy,
    output int ref_count,
    output int ref_period
);
    int gap;
    // The sequencer issues a read the moment it is asked to
    assign read_cmd = rd_go;
    // A refresh keeps the sequencer busy for one cycle while it runs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            seq_busy <= 1'b0;
            ref_count <= 0;
            ref_period <= 0;
            gap <= 0;
        end else begin
            seq_busy <= refresh_req;
            gap <= refresh_req ? 0 : gap + 1;
            if (refresh_req) begin
                ref_count <= ref_count + 1;
                ref_period <= gap + 1;
            end
        end
    end
endmodule

// File: verification/sgram_controller_config_tb.sv
`timescale 1ns/100ps
module sgram_controller_config_tb;
    import scc_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, arb_busy = 1'b0, cl_valid = 1'b0, rd_go = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, cl_addr = 32'h0;
    logic [2:0] cas = 3'h3;
    logic rd_valid, ready, taken, sel3, sel4, wide, bwe, bwm, phd, rlatch, dqm, refq, rcmd, sbusy;
    logic [13:0] row;
    logic [7:0] col;
    logic [1:0] bank, iftype;
    logic [12:0] apm;
    logic [4:0] bwcols;
    logic cap_r, cap_f, rcv_r, rcv_f;
    logic [1:0] wdh, wdt;
    logic [3:0] opm;
    logic [15:0] win;
    int errors = 0, num_checks = 0, rcount, rper, n;
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    scc_seq_model seq_u (.ref_clk(ref_clk), .rst(rst), .refresh_req(refq), .rd_go(rd_go), .read_cmd(rcmd),
        .seq_busy(sbusy), .ref_count(rcount), .ref_period(rper));
    scc_core dut_u (.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr), .reg_be(4'hf), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_valid(rd_valid), .cas_latency(cas),
        .sequencer_busy_in(sbusy), .arbiter_busy_in(arb_busy), .client_req_valid(cl_valid),
        .client_byte_addr(cl_addr), .client_req_ready(ready), .client_req_taken(taken), .row_addr(row),
        .col_addr(col), .bank_addr(bank), .third_chip_select(sel3), .fourth_chip_select(sel4),
        .autoprecharge_mask(apm), .mem_if_type(iftype), .wide_data_bus(wide), .block_write_enable(bwe),
        .block_write_byte_mask(bwm), .block_write_columns(bwcols), .sequencer_operating_mode(opm),
        .page_hiding_disable(phd), .read_cmd(rcmd), .read_capture_enable_rise(cap_r),
        .read_capture_enable_fall(cap_f), .data_receive_enable_rise(rcv_r), .data_receive_enable_fall(rcv_f),
        .read_data_latch(rlatch), .dqm_on_read(dqm), .write_data_delay_halves(wdh), .write_drive_timing(wdt),
        .refresh_req(refq));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk) #1 reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
        @(posedge ref_clk) #1 reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge ref_clk) #1 reg_addr = a; reg_rd = 1'b1;
        @(posedge ref_clk) #1 reg_rd = 1'b0;
        chk("rd_valid", {31'h0, rd_valid}, 32'h1);
        chk("rdata", reg_rdata, exp);
    endtask
    task automatic req(input logic [31:0] a);
        @(posedge ref_clk) #1 cl_addr = a; cl_valid = 1'b1;
        @(posedge ref_clk) #1 cl_valid = 1'b0;
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic t_regs();
        rd(SCC_OFS_CNTL, 32'h0800_0000);
        rd(SCC_OFS_ADDR, 32'h0000_0000);
        rd(12'h100, 32'h0);
        arb_busy = 1'b1;
        // Busy positions written as ones must still read back live values only
        wr(SCC_OFS_CNTL, 32'h0870_0000);
        rd(SCC_OFS_CNTL, 32'h0850_0000);
        arb_busy = 1'b0;
        rd(SCC_OFS_CNTL, 32'h0800_0000);
        $display("test regs done");
    endtask
    task automatic t_lock();
        wr(SCC_OFS_CNTL, 32'h0880_0000);
        chk("ready", {31'h0, ready}, 32'h0);
        req(32'h0);
        chk("taken", {31'h0, taken}, 32'h0);
        wr(SCC_OFS_CNTL, 32'h0800_0000);
        req(32'h0);
        chk("taken", {31'h0, taken}, 32'h1);
        $display("test lock done");
    endtask
    task automatic t_decode();
        for (int i = 0; i < 5; i++) begin
            wr(SCC_OFS_ADDR, (i << 4) | ((i & 1) << 8) | ((i & 3) << 20));
            chk("apm", {19'h0, apm}, 32'h100 << i);
            chk("wide", {31'h0, wide}, i & 1);
            chk("bwe", {31'h0, bwe}, (i >> 1) & 1);
            chk("bwm", {31'h0, bwm}, ((i & 3) == 3) ? 1 : 0);
        end
        for (int t = 0; t < 3; t++) begin
            wr(SCC_OFS_CNTL, 32'h0800_0000 | t | ((t & 1) << 3) | (t << 16));
            chk("iftype", {30'h0, iftype}, t);
            chk("bwcols", {27'h0, bwcols}, (t & 1) ? 16 : 8);
            chk("phd", {31'h0, phd}, (t == 1) ? 1 : 0);
            chk("opm", {28'h0, opm}, t);
        end
        $display("test decode done");
    endtask
    task automatic t_latch();
        for (int c = 0; c < 4; c++) begin
            wr(SCC_OFS_CNTL, 32'h0800_0000 | (c << 8) | ((c & 1) << 26));
            @(posedge ref_clk) #1 rd_go = 1'b1;
            #1 chk("dqm", {31'h0, dqm}, ~c & 1);
            n = 0;
            for (int i = 1; i < 9; i++) begin
                @(posedge ref_clk) #1 rd_go = 1'b0;
                if (rlatch === 1'b1 && n == 0) n = i;
            end
            chk("latch_delay", n, c + 1);
        end
        $display("test latch done");
    endtask
    task automatic t_map();
        // Checkerboard code 1 flips byte bit 11 before the 64-bit word split
        wr(SCC_OFS_ADDR, 32'h0001_0000);
        req(32'h0000_0800);
        chk("bank", {30'h0, bank}, 32'h0);
        chk("col", {24'h0, col}, 32'h0);
        req(32'h0000_0000);
        chk("bank", {30'h0, bank}, 32'h1);
        chk("row", {18'h0, row}, 32'h0);
        // Row bit 12 sits at byte bit 24 for 8 column bits, 2 banks and a 64-bit bus
        wr(SCC_OFS_ADDR, 32'h0000_0002);
        req(32'h0100_0000);
        chk("sel3", {31'h0, sel3}, 32'h1);
        chk("sel4", {31'h0, sel4}, 32'h0);
        wr(SCC_OFS_ADDR, 32'h0000_0004);
        req(32'h0200_0000);
        chk("sel3", {31'h0, sel3}, 32'h0);
        chk("sel4", {31'h0, sel4}, 32'h1);
        $display("test map done");
    endtask
    task automatic window(output logic [15:0] w);
        w = '0;
        @(posedge ref_clk) #1 rd_go = 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk) #1 rd_go = 1'b0;
            w[k] = cap_r;
            w[k + 4] = cap_f;
            w[k + 8] = rcv_r;
            w[k + 12] = rcv_f;
        end
    endtask
    task automatic t_window();
        // Bit k of each nibble is clock k+1 after the read; order rcv_f, rcv_r, cap_f, cap_r
        wr(SCC_OFS_CNTL, 32'h0a00_f021);
        chk("wdh", {30'h0, wdh}, 32'h2);
        chk("wdt", {30'h0, wdt}, 32'h3);
        window(win);
        chk("win_cl3", {16'h0, win}, 32'h6644);
        cas = 3'h2;
        wr(SCC_OFS_CNTL, 32'h0800_0011);
        window(win);
        chk("win_cl2", {16'h0, win}, 32'h1112);
        wr(SCC_OFS_CNTL, 32'h0800_0032);
        window(win);
        chk("win_always", {16'h0, win}, 32'h11ff);
        wr(SCC_OFS_CNTL, 32'h0800_0030);
        window(win);
        chk("win_1to1", {16'h0, win}, 32'h0);
        cas = 3'h3;
        $display("test window done");
    endtask
    task automatic t_refresh();
        wr(SCC_OFS_CNTL, 32'h0000_0000);
        for (int i = 0; i < 400 && rcount < 2; i++) @(posedge ref_clk);
        if (rcount < 2) begin
            errors++;
            results();
        end
        chk("period", rper, 156);
        wr(SCC_OFS_CNTL, 32'h0800_0000);
        n = rcount;
        repeat (400) @(posedge ref_clk);
        chk("no_refresh", rcount, n);
        $display("test refresh done");
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        #1 rst = 1'b0;
        t_regs();
        t_lock();
        t_decode();
        t_latch();
        t_map();
        t_window();
        t_refresh();
        results();
    end
endmodule
